// >>> fbrg_consts.svh
// Constants for the fractional baud rate generator and receive sampler.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef FBRG_CONSTS_SVH
`define FBRG_CONSTS_SVH

// ***********************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ***********************************************************
`define FBRG_OFF_CTRL 8'h00
`define FBRG_OFF_STATUS 8'h04
`define FBRG_OFF_DATA 8'h08

// ***********************************************************
// Control register fields
// ***********************************************************
`define FBRG_CTRL_SEL_LSB 0
`define FBRG_CTRL_SEL_MSB 11
`define FBRG_CTRL_SCALE_LSB 12
`define FBRG_CTRL_SCALE_MSB 15
`define FBRG_CTRL_DBL_BIT 16
`define FBRG_CTRL_EN_BIT 17
`define FBRG_CTRL_LEN_LSB 18
`define FBRG_CTRL_LEN_MSB 21
`define FBRG_CTRL_RESET 32'h00280000

// ***********************************************************
// Status register fields
// ***********************************************************
`define FBRG_STAT_DONE_BIT 0
`define FBRG_STAT_FRAME_ERROR_FLAG_BIT 1
`define FBRG_STAT_BUSY_BIT 2

// ***********************************************************
// Sampling figures
// ***********************************************************
`define FBRG_SAMPLES_NORMAL 5'h10
`define FBRG_SAMPLES_DOUBLE 5'h08
`define FBRG_FIRST_NORMAL 5'h08
`define FBRG_FIRST_DOUBLE 5'h04
`define FBRG_MIDDLE_NORMAL 5'h09
`define FBRG_MIDDLE_DOUBLE 5'h05
`define FBRG_LEN_MIN 4'h5
`define FBRG_LEN_MAX 4'ha

`endif

// >>> fbrg_core.sv
// Receive timing core: APB registers, baud tick generator and the
// oversampling sequencer with three-sample majority voting.
// Assumes APB master on ref_clk and a receive line synchronous to it.
`include "fbrg_consts.svh"

module fbrg_core #(
  parameter int ADDR_W = 12,
  parameter int SEL_W = 12,
  parameter int LEN_MAX = 10
) (
  input wire logic ref_clk, // System clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rxLine, // Serial receive line
  output logic [LEN_MAX-1:0] rxData, // Last received character
  output logic rxValid, // Pulse when a frame ends
  output logic frameErrorFlag // Sticky frame error
);

  if (ADDR_W <= 8 || SEL_W != 12 || LEN_MAX != 10) begin : g_chk
    $error("unsupported parameter value");
  end

  // ***********************************************************
  // Decoding helpers
  // ***********************************************************
  // Address match against an 8-bit offset
  function automatic logic addrHit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addrHit = (a == {{(ADDR_W-8){1'b0}}, off});
  endfunction

  // Two out of three vote
  function automatic logic majority(input logic a, input logic b,
                                    input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // Length field held to the supported range
  function automatic logic [3:0] clampLen(input logic [3:0] v);
    if (v < `FBRG_LEN_MIN) begin
      clampLen = `FBRG_LEN_MIN;
    end else if (v > `FBRG_LEN_MAX) begin
      clampLen = `FBRG_LEN_MAX;
    end else begin
      clampLen = v;
    end
  endfunction

  // ***********************************************************
  // Register state
  // ***********************************************************
  logic [SEL_W-1:0] periodSel_q;
  fbrg_pkg::fbrg_scale_t scale_q;
  logic doubleSpeedSel_q;
  logic rxEnable_q;
  logic [3:0] lenRaw_q;
  logic rxDone_q;
  logic busy;
  logic [3:0] dataLen;
  logic access;
  logic wrStrobe;
  logic hitCtrl;
  logic hitStat;
  logic hitData;
  logic clrDone;
  logic clrFerr;
  logic setDone;
  logic setFerr;

  assign dataLen = clampLen(lenRaw_q);
  assign hitCtrl = addrHit(paddr, `FBRG_OFF_CTRL);
  assign hitStat = addrHit(paddr, `FBRG_OFF_STATUS);
  assign hitData = addrHit(paddr, `FBRG_OFF_DATA);
  assign access = psel & penable & pready;
  assign wrStrobe = access & pwrite;
  assign clrDone = wrStrobe & hitStat & pwdata[`FBRG_STAT_DONE_BIT];
  assign clrFerr = wrStrobe & hitStat & pwdata[`FBRG_STAT_FRAME_ERROR_FLAG_BIT];

  // ***********************************************************
  // APB slave
  // ***********************************************************
  // One wait state: ready rises on the second access cycle, which
  // lets read data come straight from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(hitCtrl || hitStat || hitData);
      prdata <= 32'h0;
      if (!pwrite && hitCtrl) begin
        prdata[`FBRG_CTRL_SEL_MSB:`FBRG_CTRL_SEL_LSB] <= periodSel_q;
        prdata[`FBRG_CTRL_SCALE_MSB:`FBRG_CTRL_SCALE_LSB] <= scale_q;
        prdata[`FBRG_CTRL_DBL_BIT] <= doubleSpeedSel_q;
        prdata[`FBRG_CTRL_EN_BIT] <= rxEnable_q;
        prdata[`FBRG_CTRL_LEN_MSB:`FBRG_CTRL_LEN_LSB] <= lenRaw_q;
      end else if (!pwrite && hitStat) begin
        prdata[`FBRG_STAT_DONE_BIT] <= rxDone_q;
        prdata[`FBRG_STAT_FRAME_ERROR_FLAG_BIT] <= frameErrorFlag;
        prdata[`FBRG_STAT_BUSY_BIT] <= busy;
      end else if (!pwrite && hitData) begin
        prdata[LEN_MAX-1:0] <= rxData;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register; change settings only while the line is idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periodSel_q <= SEL_W'(`FBRG_CTRL_RESET);
      scale_q <= 4'sh0;
      doubleSpeedSel_q <= 1'b0;
      rxEnable_q <= 1'b0;
      lenRaw_q <= 4'(`FBRG_CTRL_RESET >> `FBRG_CTRL_LEN_LSB);
    end else if (wrStrobe && hitCtrl) begin
      periodSel_q <= pwdata[`FBRG_CTRL_SEL_MSB:`FBRG_CTRL_SEL_LSB];
      scale_q <= pwdata[`FBRG_CTRL_SCALE_MSB:`FBRG_CTRL_SCALE_LSB];
      doubleSpeedSel_q <= pwdata[`FBRG_CTRL_DBL_BIT];
      rxEnable_q <= pwdata[`FBRG_CTRL_EN_BIT];
      lenRaw_q <= pwdata[`FBRG_CTRL_LEN_MSB:`FBRG_CTRL_LEN_LSB];
    end
  end

  // Sticky status; a new frame in the clearing cycle wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxDone_q <= 1'b0;
      frameErrorFlag <= 1'b0;
    end else begin
      rxDone_q <= setDone | (rxDone_q & ~clrDone);
      frameErrorFlag <= setFerr | (frameErrorFlag & ~clrFerr);
    end
  end

  // ***********************************************************
  // Baud tick generator
  // ***********************************************************
  logic tick;

  fbrg_tick_gen #(
    .SEL_W(SEL_W)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(rxEnable_q),
    .periodSel(periodSel_q),
    .scale(scale_q),
    .tick(tick)
  );

  // ***********************************************************
  // Oversampling sequencer
  // ***********************************************************
  fbrg_pkg::fbrg_state_e state_q;
  logic [4:0] sampleCnt_q;
  logic [4:0] sampleNum;
  logic [4:0] samplesPerBit;
  logic [4:0] firstSample;
  logic [4:0] middleSample;
  logic [4:0] lastSample;
  logic [1:0] vote_q;
  logic bitVal;
  logic lineHigh_q;
  logic [3:0] bitIdx_q;
  logic [LEN_MAX-1:0] shift_q;
  logic decide;

  // Sample window positions depend on the speed mode
  always_comb begin
    if (doubleSpeedSel_q) begin
      samplesPerBit = `FBRG_SAMPLES_DOUBLE;
      firstSample = `FBRG_FIRST_DOUBLE;
      middleSample = `FBRG_MIDDLE_DOUBLE;
    end else begin
      samplesPerBit = `FBRG_SAMPLES_NORMAL;
      firstSample = `FBRG_FIRST_NORMAL;
      middleSample = `FBRG_MIDDLE_NORMAL;
    end
    lastSample = firstSample + 5'h2;
  end

  assign busy = (state_q != fbrg_pkg::FBRG_IDLE);
  assign sampleNum = sampleCnt_q + 5'h1;
  assign decide = tick && busy && (sampleNum == lastSample);
  assign bitVal = majority(vote_q[0], vote_q[1], rxLine);
  assign setDone = decide && (state_q == fbrg_pkg::FBRG_STOP);
  assign setFerr = setDone && !bitVal;

  // Sample counter; the detecting tick is sample 1, wrap after the last
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sampleCnt_q <= 5'h0;
    end else if (!busy) begin
      sampleCnt_q <= {4'h0, tick & lineHigh_q & ~rxLine};
    end else if (tick) begin
      if (sampleNum == samplesPerBit) begin
        sampleCnt_q <= 5'h0;
      end else begin
        sampleCnt_q <= sampleNum;
      end
    end
  end

  // Capture the first two voting samples; the third is used live
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vote_q <= 2'h0;
    end else if (tick && busy) begin
      if (sampleNum == firstSample) begin
        vote_q[0] <= rxLine;
      end
      if (sampleNum == middleSample) begin
        vote_q[1] <= rxLine;
      end
    end
  end

  // Line level at every tick, frame included, so a low stop is no edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lineHigh_q <= 1'b0;
    end else if (!rxEnable_q) begin
      lineHigh_q <= 1'b0;
    end else if (tick) begin
      lineHigh_q <= rxLine;
    end
  end

  // Frame sequence; a new start may follow right after the stop vote,
  // which is what gives the early-start margin on the fast side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= fbrg_pkg::FBRG_IDLE;
      bitIdx_q <= 4'h0;
    end else if (!rxEnable_q) begin
      state_q <= fbrg_pkg::FBRG_IDLE;
      bitIdx_q <= 4'h0;
    end else begin
      case (state_q)
        fbrg_pkg::FBRG_IDLE: begin
          if (tick && lineHigh_q && !rxLine) begin
            state_q <= fbrg_pkg::FBRG_START;
          end
        end
        fbrg_pkg::FBRG_START: begin
          if (decide) begin
            bitIdx_q <= 4'h0;
            if (bitVal) begin
              state_q <= fbrg_pkg::FBRG_IDLE;
            end else begin
              state_q <= fbrg_pkg::FBRG_DATA;
            end
          end
        end
        fbrg_pkg::FBRG_DATA: begin
          if (decide) begin
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == dataLen - 4'h1) begin
              state_q <= fbrg_pkg::FBRG_STOP;
            end
          end
        end
        fbrg_pkg::FBRG_STOP: begin
          if (decide) begin
            state_q <= fbrg_pkg::FBRG_IDLE;
          end
        end
        default: begin
          state_q <= fbrg_pkg::FBRG_IDLE;
        end
      endcase
    end
  end

  // Data bits enter at the top, first bit ends up lowest
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (decide && state_q == fbrg_pkg::FBRG_DATA) begin
      shift_q <= {bitVal, shift_q[LEN_MAX-1:1]};
    end
  end

  // Received character and its end-of-frame pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxData <= '0;
      rxValid <= 1'b0;
    end else begin
      rxValid <= setDone;
      if (setDone) begin
        rxData <= shift_q >> (4'(LEN_MAX) - dataLen);
      end
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  // Sample counter wraps exactly at the samples-per-bit figure
  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
    (busy && tick && sampleNum == samplesPerBit && rxEnable_q)
    |=> sampleCnt_q == 5'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("sample counter did not wrap");

  // First voting sample is taken on the right tick
  property p_first;
    @(posedge ref_clk) disable iff (rst)
    (busy && tick && sampleNum == firstSample)
    |=> vote_q[0] == $past(rxLine);
  endproperty
  a_first: assert property (p_first)
    else $error("first vote sample missed");

  // Middle voting sample is taken on the right tick
  property p_middle;
    @(posedge ref_clk) disable iff (rst)
    (busy && tick && sampleNum == middleSample)
    |=> vote_q[1] == $past(rxLine);
  endproperty
  a_middle: assert property (p_middle)
    else $error("middle vote sample missed");

  // A high-voted start bit sends the sequencer back to idle
  property p_reject;
    @(posedge ref_clk) disable iff (rst)
    (rxEnable_q && state_q == fbrg_pkg::FBRG_START && decide && bitVal)
    |=> state_q == fbrg_pkg::FBRG_IDLE;
  endproperty
  a_reject: assert property (p_reject)
    else $error("noise start not rejected");

  // Zero stop bit raises the frame error flag next cycle
  property p_frame_error_flag;
    @(posedge ref_clk) disable iff (rst)
    setFerr |=> frameErrorFlag && rxValid;
  endproperty
  a_frame_error_flag: assert property (p_frame_error_flag)
    else $error("frame error not flagged");

  // The effective length never leaves five to ten
  property p_len;
    @(posedge ref_clk) disable iff (rst)
    dataLen >= `FBRG_LEN_MIN && dataLen <= `FBRG_LEN_MAX;
  endproperty
  a_len: assert property (p_len)
    else $error("length out of range");

  // A frame ends only from the stop state with a decision
  property p_valid;
    @(posedge ref_clk) disable iff (rst)
    rxValid |-> $past(state_q) == fbrg_pkg::FBRG_STOP && $past(decide);
  endproperty
  a_valid: assert property (p_valid)
    else $error("frame end without stop vote");

endmodule

// >>> fbrg_pkg.sv
// Types shared by the baud generator and the receive sampler.
// Assumes the constants header is on the include path.
package fbrg_pkg;

  // Signed scale factor: positive multiplies, negative adds fractions
  typedef logic signed [3:0] fbrg_scale_t;

  // Receive sequencer states
  typedef enum logic [1:0] {
    FBRG_IDLE,
    FBRG_START,
    FBRG_DATA,
    FBRG_STOP
  } fbrg_state_e;

endpackage

// >>> fbrg_serial_tx.sv
// Far-end serial transmitter model driving the core's receive line.
// Assumes the core samples rxLine on ref_clk; the line idles high.
module fbrg_serial_tx (
  input wire logic ref_clk, // System clock
  output logic rxLine // Serial line, idle high
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****
  // Line driver
  // ****
  // Idle level until the first frame
  initial rxLine = 1'b1;

  // One frame: start, len bits LSB first, one stop, optional edge noise
  task automatic send(input logic [9:0] d, input int len, input int per,
                      input logic stp, input logic gl);
    logic lvl;
    for (int b = 0; b <= len + 1; b++) begin
      // Bit time set by caller; its error shares the budget
      for (int c = 0; c < per; c++) begin
        lvl = (b == 0) ? 1'b0 : (b > len) ? stp : d[b-1];
        // Noise kept off the centre, so a correct vote ignores it
        if (gl && b > 0 && b <= len && (c < per / 4 || c >= 3 * per / 4))
          lvl = ~lvl;
        @(posedge ref_clk);
        rxLine <= lvl;
      end
    end
    @(posedge ref_clk);
    rxLine <= 1'b1;
    // Idle gap so the receiver sees a high sample before the next start
    repeat (2 * per) @(posedge ref_clk);
  endtask

  // Short low pulse on an idle line, like a noise spike
  task automatic spike(input int n);
    @(posedge ref_clk);
    rxLine <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rxLine <= 1'b1;
  endtask
endmodule

// >>> fbrg_tick_gen.sv
// Baud tick generator: down counter reloaded from the period select,
// stretched by a positive scale or dithered by a negative scale.
// Assumes one clock and a config that is static while enabled.
`include "fbrg_consts.svh"

module fbrg_tick_gen #(
  parameter int SEL_W = 12
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic enable, // Run the counter
  input wire logic [SEL_W-1:0] periodSel, // Baud period select
  input wire fbrg_pkg::fbrg_scale_t scale, // Signed scale factor
  output logic tick // One-cycle baud tick
);

  localparam int CNT_W = SEL_W + 8;

  if (SEL_W < 8 || SEL_W > 16) begin : g_chk
    $error("SEL_W out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reload_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [SEL_W:0] fracSum;
  logic [3:0] mag;

  // ***********************************************************
  // Reload value for the next tick period
  // ***********************************************************
  // Negative scale: carry the remainder so the fraction spreads out
  always_comb begin
    mag = 4'(~scale + 4'h1);
    fracSum = (SEL_W+1)'({{(SEL_W-7){1'b0}}, acc_q}) + {1'b0, periodSel};
    if (scale[3]) begin
      reload_d = CNT_W'(fracSum >> mag);
      acc_d = 8'(fracSum & ((SEL_W+1)'(1) << mag) - (SEL_W+1)'(1));
    end else begin
      reload_d = CNT_W'((({8'h0, periodSel} + CNT_W'(1)) << scale)
                 - CNT_W'(1));
      acc_d = 8'h0;
    end
  end

  // ***********************************************************
  // Counter and tick
  // ***********************************************************
  // A tick leaves whenever the count reaches zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      acc_q <= 8'h0;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_q <= '0;
      acc_q <= 8'h0;
      tick <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= reload_d;
      acc_q <= acc_d;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - CNT_W'(1);
      tick <= 1'b0;
    end
  end

  // Zero select, zero scale: a tick on every cycle
  property p_full_rate;
    @(posedge ref_clk) disable iff (rst)
    (enable && $past(enable) && tick && periodSel == '0 && scale == 4'sh0
     && $stable(periodSel) && $stable(scale))
    |=> tick;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("tick missing at full rate");

  // Scale -1, select 1: periods alternate 1 and 2 cycles
  property p_half_step;
    @(posedge ref_clk) disable iff (rst)
    (enable && $past(enable, 2) && periodSel == SEL_W'(1)
     && scale == -4'sh1 && tick && $past(tick))
    |=> !tick ##1 tick;
  endproperty
  a_half_step: assert property (p_half_step)
    else $error("extra cycle not inserted");

  // Scale +1, select 0: period doubles to two cycles
  property p_pos_scale;
    @(posedge ref_clk) disable iff (rst)
    (enable && $past(enable) && periodSel == '0 && scale == 4'sh1 && tick
     && $stable(periodSel) && $stable(scale))
    |=> !tick ##1 tick;
  endproperty
  a_pos_scale: assert property (p_pos_scale)
    else $error("positive scale period wrong");

endmodule

// >>> tb.sv
// Self-checking bench for the receive timing core over APB.
// Assumes the core's one-wait-state APB and a 10 MHz ref_clk.
`include "fbrg_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic rxLine, rxValid, frameErrorFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] rxData;
  int nFail = 0;
  int nTests = 0;
  int nValid = 0;

  fbrg_core fbrg_core_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxLine(rxLine),
    .rxData(rxData), .rxValid(rxValid), .frameErrorFlag(frameErrorFlag));
  fbrg_serial_tx fbrg_serial_tx_inst (.ref_clk(ref_clk), .rxLine(rxLine));

  // ****
  // Clock, monitors and reporting
  // ****
  // 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Count frame-end pulses; a pulse lasts one cycle
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1) nValid++;
  end

  // Hang guard, well above the longest run
  initial begin
    repeat (90000) @(posedge ref_clk);
    nFail++;
    wrapUp();
  end

  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ****
  // APB master
  // ****
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nFail++;
      wrapUp();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk("slvErr", {31'h0, e}, {31'h0, xe});
  endtask

  // Enabled control word: length, double speed, scale, period select
  function automatic logic [31:0] cfg(input logic [11:0] sel,
      input logic [3:0] sc, input logic dbl, input logic [3:0] len);
    cfg = {10'h0, len, 1'b1, dbl, sc, sel};
  endfunction

  // ****
  // Receive scenario
  // ****
  // nom is the receiver bit time in clocks, per the sender's
  task automatic rxCase(input logic [11:0] sel, input logic [3:0] sc,
      input logic dbl, input int len, input int nom, input int per,
      input logic [9:0] d, input logic stp, input logic gl);
    int cnt, expc, v0;
    logic ok;
    logic [9:0] m;
    wr(12'h000, cfg(sel, sc, dbl, len[3:0]));
    repeat (nom) @(posedge ref_clk);
    v0 = nValid;
    cnt = 0;
    m = ~(10'h3ff << len);
    fork
      fbrg_serial_tx_inst.send(d, len, per, stp, gl);
      begin
        @(negedge rxLine);
        while (rxValid !== 1'b1 && cnt < 20 * nom) begin
          @(posedge ref_clk);
          cnt++;
        end
      end
    join
    if (cnt >= 20 * nom) begin
      nFail++;
      wrapUp();
    end
    // Stop decision at sample 10 of 16, or 6 of 8, in receiver time
    expc = (len + 1) * nom + nom * (dbl ? 6 : 10) / (dbl ? 8 : 16);
    ok = (cnt >= expc - nom / 8 - 3) && (cnt <= expc + nom / 8 + 3);
    chk("stopTiming", {31'h0, ok}, 32'h1);
    chk("rxData", {22'h0, rxData}, {22'h0, d & m});
    chk("frameErr", {31'h0, frameErrorFlag}, {31'h0, ~stp});
    rdchk("status", 12'h004, {30'h0, ~stp, 1'b1}, 1'b0);
    // Counted after a few edges, so the pulse monitor has run
    chk("validCount", 32'(nValid - v0), 32'h1);
    wr(12'h004, 32'h3);
    @(posedge ref_clk);
    chk("ferrClear", {31'h0, frameErrorFlag}, 32'h0);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("ctrlReset", 12'h000, `FBRG_CTRL_RESET, 1'b0);
    rdchk("statusReset", 12'h004, 32'h0, 1'b0);
    rdchk("dataReset", 12'h008, 32'h0, 1'b0);
    rdchk("unmapped", 12'h00c, 32'h0, 1'b1);
    wr(12'h008, 32'h3ff);
    wr(12'h00c, 32'hffffffff);
    rdchk("dataReadOnly", 12'h008, 32'h0, 1'b0);
    rdchk("ctrlKept", 12'h000, `FBRG_CTRL_RESET, 1'b0);
    // Rate, mode and length table; negative scales kept in limit
    rxCase(12'h000, 4'h0, 1'b0, 8, 16, 16, 10'h0a5, 1'b1, 1'b0);
    rxCase(12'h001, 4'h0, 1'b0, 10, 32, 32, 10'h2b5, 1'b1, 1'b0);
    rxCase(12'h000, 4'h0, 1'b1, 5, 8, 8, 10'h015, 1'b1, 1'b0);
    rxCase(12'h000, 4'h1, 1'b1, 10, 16, 16, 10'h1c7, 1'b1, 1'b0);
    rxCase(12'h001, 4'hf, 1'b0, 8, 24, 24, 10'h03c, 1'b1, 1'b0);
    rxCase(12'h003, 4'he, 1'b0, 7, 28, 28, 10'h05a, 1'b1, 1'b0);
    rxCase(12'h000, 4'h2, 1'b0, 6, 64, 64, 10'h02a, 1'b1, 1'b0);
    rxCase(12'h000, 4'h0, 1'b0, 9, 16, 16, 10'h1aa, 1'b1, 1'b1);
    rxCase(12'h000, 4'h1, 1'b0, 8, 32, 31, 10'h0c3, 1'b1, 1'b0);
    rxCase(12'h000, 4'h1, 1'b0, 8, 32, 33, 10'h03c, 1'b1, 1'b0);
    rxCase(12'h000, 4'h0, 1'b0, 8, 16, 16, 10'h081, 1'b0, 1'b0);
    // Low for samples 1-8 loses the vote, 1-9 wins: pins the 8-9-10 window
    wr(12'h000, cfg(12'h000, 4'h0, 1'b0, 4'h8));
    fbrg_serial_tx_inst.spike(8);
    repeat (200) @(posedge ref_clk);
    rdchk("spikeRejected", 12'h004, 32'h0, 1'b0);
    fbrg_serial_tx_inst.spike(9);
    repeat (200) @(posedge ref_clk);
    rdchk("spikeAccepted", 12'h004, 32'h1, 1'b0);
    chk("spikeData", {22'h0, rxData}, 32'h0ff);
    wrapUp();
  end
endmodule
